// ### src/slr_fifo.sv
// word fifo between the store strobe and the holding register
// assumes one clock; DEPTH is any value above one; read data leave a register
`timescale 1ns/100ps
`default_nettype none
module slr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic out_v;
    logic [WIDTH-1:0] out_d;
  } slr_fifo_state_t;

  slr_fifo_state_t q;
  slr_fifo_state_t d;
  logic push;
  logic take;
  logic load;

  // cnt counts the output register as well, so no more than DEPTH words are held
  assign in_ready = (q.cnt != FULL);
  assign out_valid = q.out_v;
  assign out_data = q.out_d;

  always_comb begin
    d = q;
    push = in_valid && in_ready;
    take = q.out_v && out_ready;
    // refill the output register when it empties or is taken this cycle
    load = (q.cnt != CW'(q.out_v)) && (!q.out_v || out_ready);
    if (take) begin
      d.out_v = 1'b0;
    end
    if (push) begin
      d.mem[q.wptr] = in_data;
      d.wptr = (q.wptr == LAST) ? '0 : q.wptr + 1'b1;
    end
    if (load) begin
      d.out_d = q.mem[q.rptr];
      d.out_v = 1'b1;
      d.rptr = (q.rptr == LAST) ? '0 : q.rptr + 1'b1;
    end
    if (push && !take) begin
      d.cnt = q.cnt + 1'b1;
    end else if (take && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (flush) begin
      d.wptr = '0;
      d.rptr = '0;
      d.cnt = '0;
      d.out_v = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // slr_fifo
`default_nettype wire

// ### src/slr_pkg.sv
// package for the serial LED switch register: widths, depths, reset values, pin bundles
// assumes a single 100 MHz core clock that samples every link pin
`default_nettype none
package slr_pkg;

  localparam int SLR_WIDTH = 8;
  localparam int SLR_FIFO_DEPTH = 32;
  localparam logic [SLR_WIDTH-1:0] SLR_SHIFT_RESET = 8'h00;
  localparam logic [SLR_WIDTH-1:0] SLR_HOLD_RESET = 8'h00;
  localparam logic [SLR_WIDTH-1:0] SLR_DRAIN_OFF = 8'h00;

  // the three link pins sampled together
  typedef struct packed {
    logic clk;
    logic store;
    logic data;
  } slr_link_t;

  // level pins that steer the drain stage
  typedef struct packed {
    logic clear_n;
    logic disable_out;
    logic overheat;
  } slr_ctrl_t;

endpackage
`default_nettype wire

// ### src/slr_top.sv
// serial-in, parallel-out switch register driving eight open-drain outputs
// assumes all link and control pins are asynchronous to CLK and CLK is far faster
// than the link clock; the open-drain wire is resolved outside from DRAIN_OUTPUTS_OE
//
// Behaviour
// - serial shift register feeds an eight-bit holding register.
// - each rising link clock shifts the data pin into the shift register.
// - rising store strobe copies the whole shift register towards the holding register.
// - holding register changes only when a queued word is delivered with UPDATE_READY high, or on clear.
// - clear low zeroes shift and holding registers and opens every drain.
// - eight open-drain outputs follow the stored bits.
// - output disable high forces every drain off.
// - overheat flag turns every drain off.
// - drains resume by themselves once overheat clears.
// - word arrives msb first; bit n drives drain n, one means on.
// - chain output shows outgoing bit, changed on falling link clock.
// - output disable and overheat each hold every drain off; pulsing disable modulates the drains only while overheat is low.
`timescale 1ns/100ps
`default_nettype none
module slr_top #(
  parameter int WIDTH = slr_pkg::SLR_WIDTH,
  parameter int FIFO_DEPTH = slr_pkg::SLR_FIFO_DEPTH
) (
  // core clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // three-wire link
  input wire logic LINK_CLK,
  input wire logic STORE_STROBE,
  input wire logic SERIAL_DATA_IN,
  output logic CHAIN_DATA_OUT,
  // control pins
  input wire logic CLEAR_N,
  input wire logic OUTPUT_DISABLE,
  input wire logic OVERHEAT_CUTOFF,
  // word queue handshake
  output logic STORE_READY,
  input wire logic UPDATE_READY,
  // open-drain outputs
  output logic [WIDTH-1:0] DRAIN_OUTPUTS_O,
  output logic [WIDTH-1:0] DRAIN_OUTPUTS_OE
);

  typedef struct packed {
    slr_pkg::slr_link_t link_s1;
    slr_pkg::slr_link_t link_s2;
    slr_pkg::slr_link_t link_prev;
    slr_pkg::slr_ctrl_t ctrl_s1;
    slr_pkg::slr_ctrl_t ctrl_s2;
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] hold;
    logic chain;
    logic [WIDTH-1:0] drain;
  } slr_state_t;

  slr_state_t q;
  slr_state_t d;

  logic clk_rise;
  logic clk_fall;
  logic store_rise;
  logic clearing;
  logic cutoff;
  logic fifo_valid;
  logic [WIDTH-1:0] fifo_data;
  logic fifo_ready;
  logic drains_allowed;
  logic [WIDTH-1:0] drain_next;

  // edges look only at second and third stages, never at the first
  assign clk_rise = q.link_s2.clk && !q.link_prev.clk;
  assign clk_fall = !q.link_s2.clk && q.link_prev.clk;
  assign store_rise = q.link_s2.store && !q.link_prev.store;
  assign clearing = !q.ctrl_s2.clear_n;
  // disable high suspends the thermal cutoff entirely
  assign cutoff = q.ctrl_s2.overheat && !q.ctrl_s2.disable_out;
  // cutoff is a live level, so drains recover with no rewrite
  assign drains_allowed = !clearing && !q.ctrl_s2.disable_out && !cutoff;

  // one gate per channel: bit n of the held word steers drain n
  for (genvar n = 0; n < WIDTH; n++) begin : g_drain
    assign drain_next[n] = q.hold[n] && drains_allowed;
  end

  // words queue here so a slow consumer of the holding register can lag the host;
  // a strobe seen while the queue is full is dropped and shows on STORE_READY low
  slr_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .flush(clearing),
    .in_valid(store_rise && !clearing),
    .in_ready(fifo_ready),
    .in_data(q.shift),
    .out_valid(fifo_valid),
    .out_ready(UPDATE_READY && !clearing),
    .out_data(fifo_data)
  );

  assign STORE_READY = fifo_ready;
  assign CHAIN_DATA_OUT = q.chain;
  assign DRAIN_OUTPUTS_O = slr_pkg::SLR_DRAIN_OFF;
  assign DRAIN_OUTPUTS_OE = q.drain;

  always_comb begin
    d = q;
    d.link_s1 = '{clk: LINK_CLK, store: STORE_STROBE, data: SERIAL_DATA_IN};
    d.link_s2 = q.link_s1;
    d.link_prev = q.link_s2;
    d.ctrl_s1 = '{clear_n: CLEAR_N, disable_out: OUTPUT_DISABLE, overheat: OVERHEAT_CUTOFF};
    d.ctrl_s2 = q.ctrl_s1;
    // msb goes in first, so it ends up at the top after eight edges
    if (clk_rise) begin
      d.shift = {q.shift[WIDTH-2:0], q.link_s2.data};
    end
    // falling-edge update gives a downstream part half a period of setup
    if (clk_fall) begin
      d.chain = q.shift[WIDTH-1];
    end
    // holding register moves only when a stored word is delivered, or on clear below
    if (fifo_valid && UPDATE_READY) begin
      d.hold = fifo_data;
    end
    if (clearing) begin
      d.shift = slr_pkg::SLR_SHIFT_RESET;
      d.hold = slr_pkg::SLR_HOLD_RESET;
      d.chain = 1'b0;
    end
    d.drain = drain_next;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // slr_top
`default_nettype wire

// ### test/slr_host_model.sv
// host model driving the three-wire link
// assumes the bench calls send and strobe one at a time
`timescale 1ns/100ps
`default_nettype none
module slr_host_model (
  // core clock, used only to align each transfer
  input wire logic clk,
  // link pins
  output logic link_clk,
  output logic store,
  output logic data
);
  initial begin
    link_clk = 1'b0;
    store = 1'b0;
    data = 1'b0;
  end
  // link clock runs only inside a frame, 125 ns period
  task automatic send(input logic [7:0] w);
    @(negedge clk);
    for (int i = 7; i >= 0; i--) begin
      data = w[i];
      #31.2 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      #31.3;
    end
    data = ~data; // released line must not look like the last bit
    #60;
  endtask
  task automatic strobe();
    @(negedge clk);
    #40 store = 1'b1;
    #60 store = 1'b0;
    #60;
  endtask
endmodule // slr_host_model
`default_nettype wire

// ### test/slr_props.sv
// port checker for slr_top
// assumes bind onto slr_top and one core clock domain
`timescale 1ns/100ps
`default_nettype none
module slr_props #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // link pins
  input wire logic LINK_CLK,
  input wire logic STORE_STROBE,
  input wire logic SERIAL_DATA_IN,
  input wire logic CHAIN_DATA_OUT,
  // control pins
  input wire logic CLEAR_N,
  input wire logic OUTPUT_DISABLE,
  input wire logic OVERHEAT_CUTOFF,
  // word queue handshake
  input wire logic STORE_READY,
  input wire logic UPDATE_READY,
  // open-drain outputs
  input wire logic [WIDTH-1:0] DRAIN_OUTPUTS_O,
  input wire logic [WIDTH-1:0] DRAIN_OUTPUTS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // no word can reach the holding register and no control pin moves
  sequence quiet_s;
    (!UPDATE_READY && CLEAR_N && !OUTPUT_DISABLE && !OVERHEAT_CUTOFF)[*5];
  endsequence
  chk_drain_low: assert property (DRAIN_OUTPUTS_O == '0)
    else $error("drain data not low");
  chk_disable_off: assert property (OUTPUT_DISABLE[*4] |-> DRAIN_OUTPUTS_OE == '0)
    else $error("drains on while disabled");
  chk_clear_off: assert property ((!CLEAR_N)[*4] |-> DRAIN_OUTPUTS_OE == '0)
    else $error("drains on while cleared");
  chk_chain_clear: assert property ((!CLEAR_N)[*4] |-> !CHAIN_DATA_OUT)
    else $error("chain output not cleared");
  chk_heat_off: assert property (OVERHEAT_CUTOFF[*4] |-> DRAIN_OUTPUTS_OE == '0)
    else $error("drains on while hot");
  chk_hold_stable: assert property (quiet_s |-> $stable(DRAIN_OUTPUTS_OE))
    else $error("drains moved without a store");
  chk_chain_edge: assert property ($changed(CHAIN_DATA_OUT) |-> !LINK_CLK)
    else $error("chain output moved while link clock high");
  chk_oe_cause: assert property (|(DRAIN_OUTPUTS_OE & ~$past(DRAIN_OUTPUTS_OE))
    |-> $past(CLEAR_N) && !$past(OUTPUT_DISABLE))
    else $error("drain turned on while blocked");
endmodule // slr_props
bind slr_top slr_props #(
  .WIDTH(WIDTH)
) u_props (
  .CLK(CLK),
  .RST_N(RST_N),
  .LINK_CLK(LINK_CLK),
  .STORE_STROBE(STORE_STROBE),
  .SERIAL_DATA_IN(SERIAL_DATA_IN),
  .CHAIN_DATA_OUT(CHAIN_DATA_OUT),
  .CLEAR_N(CLEAR_N),
  .OUTPUT_DISABLE(OUTPUT_DISABLE),
  .OVERHEAT_CUTOFF(OVERHEAT_CUTOFF),
  .STORE_READY(STORE_READY),
  .UPDATE_READY(UPDATE_READY),
  .DRAIN_OUTPUTS_O(DRAIN_OUTPUTS_O),
  .DRAIN_OUTPUTS_OE(DRAIN_OUTPUTS_OE)
);
`default_nettype wire

// ### test/tb.sv
// self-checking bench for slr_top
// assumes slr_host_model drives the link pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk = 1'b0, rst_n = 1'b0, clear_n = 1'b0, dis = 1'b0, heat = 1'b0, upd = 1'b1;
  logic lclk, strb, sdat, chain, rdy;
  logic [7:0] o, oe;
  int fails = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  slr_host_model host (.clk(clk), .link_clk(lclk), .store(strb), .data(sdat));
  slr_top dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(lclk), .STORE_STROBE(strb),
    .SERIAL_DATA_IN(sdat), .CHAIN_DATA_OUT(chain), .CLEAR_N(clear_n), .OUTPUT_DISABLE(dis),
    .OVERHEAT_CUTOFF(heat), .STORE_READY(rdy), .UPDATE_READY(upd), .DRAIN_OUTPUTS_O(o),
    .DRAIN_OUTPUTS_OE(oe));
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic t_word();
    host.send(8'hA5);
    host.strobe();
    settle();
    `CHK(oe, 8'hA5)
    `CHK(chain, 1'b1)
    `CHK(o, 8'h00)
    host.send(8'h0F);
    `CHK(chain, 1'b0)
    `CHK(oe, 8'hA5)
  endtask
  task automatic t_force();
    dis = 1'b1;
    heat = 1'b1;
    settle();
    `CHK(oe, 8'h00)
    dis = 1'b0;
    settle();
    `CHK(oe, 8'h00)
    heat = 1'b0;
    settle();
    `CHK(oe, 8'hA5)
    dis = 1'b1;
    settle();
    `CHK(oe, 8'h00)
    dis = 1'b0;
    settle();
    `CHK(oe, 8'hA5)
  endtask
  task automatic t_queue();
    upd = 1'b0;
    repeat (32) host.strobe();
    `CHK(rdy, 1'b0)
    host.send(8'h3C);
    host.strobe();
    `CHK(oe, 8'hA5)
    upd = 1'b1;
    repeat (60) @(negedge clk);
    `CHK(oe, 8'h0F)
    `CHK(rdy, 1'b1)
  endtask
  task automatic t_clear();
    clear_n = 1'b0;
    settle();
    `CHK(oe, 8'h00)
    clear_n = 1'b1;
    host.strobe();
    settle();
    `CHK(oe, 8'h00)
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    settle();
    `CHK(oe, 8'h00)
    clear_n = 1'b1;
    t_word();
    t_force();
    t_queue();
    t_clear();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
